// ---- rtl/ercr_top.sv ----
// Operation
// - three parallel soft resets in registers
// - soft reset bits never clear themselves
// - register hard reset restores register defaults
// - tx, rx and register hard reset ports
// - soft resets come only from setup register
// - tx soft reset holds only tx path
// - tx soft reset drops lanes settled output
// - rx soft reset resets rx, drops ready
// - core reset resets all, drops both statuses
// - core reset leaves registers untouched
// - lanes settled only after tx clock stable
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module ercr_top
  import ercr_pkg::*;
#(
  parameter int SETTLE_CYCLES = ERCR_SETTLE_CYC
) (
  // clock and register reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // hard reset inputs
  input  wire logic        tx_rst_n,
  input  wire logic        rx_rst_n,
  // transceiver status
  input  wire logic        tx_pll_locked,
  input  wire logic        rx_link_locked,
  // wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // reset outputs to datapath, active low
  output logic             tx_path_rst_n,
  output logic             rx_path_rst_n,
  output logic             xcvr_rst_n,
  // status outputs
  output logic             tx_lanes_stable,
  output logic             rx_pcs_ready
);

  // field positions must fit the three-bit setup register
  // and the status word; a wider map would silently lose bits
  initial begin
    if (SETTLE_CYCLES < 1) $error("settle cycles must be at least one");
    if (ERCR_SOFT_TX_BIT > 2 || ERCR_SOFT_RX_BIT > 2
        || ERCR_SOFT_SYS_BIT > 2) begin
      $error("soft reset field outside the setup register");
    end
    if (ERCR_ST_XCVR_RST_BIT > 31) begin
      $error("status field outside the status word");
    end
  end

  // synchronised reset copies
  logic        rst_meta;
  logic        csr_rst_n;
  logic        tx_meta;
  logic        tx_hard_n;
  logic        rx_meta;
  logic        rx_hard_n;
  // register contents and soft reset taps
  logic [2:0]  phy_setup_register;
  logic [31:0] scratch;
  logic        soft_tx;
  logic        soft_rx;
  logic        soft_sys;
  logic        next_tx_rst_n;
  logic        next_rx_rst_n;
  logic        next_xcvr_rst_n;
  logic        tx_settled;
  logic        next_rx_ready;
  // bus strobes and read path
  logic        wb_req;
  logic        wr_setup;
  logic        wr_scratch;
  logic        rd_req;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  // apply byte enables to a stored word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // one address compare shared by the write strobes and read mux
  function automatic logic addr_hit(
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    return adr == ofs;
  endfunction

  // register reset released through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta  <= 1'b0;
      csr_rst_n <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      csr_rst_n <= rst_meta;
    end
  end

  // hard datapath resets also released synchronously
  // so the path leaves reset on a clean edge, never mid-cycle
  always_ff @(posedge sys_clk or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      tx_meta   <= 1'b0;
      tx_hard_n <= 1'b0;
    end else begin
      tx_meta   <= 1'b1;
      tx_hard_n <= tx_meta;
    end
  end

  // rx hard reset: same two-flop release as the tx side
  // a glitch shorter than a clock still clears both flops
  always_ff @(posedge sys_clk or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rx_meta   <= 1'b0;
      rx_hard_n <= 1'b0;
    end else begin
      rx_meta   <= 1'b1;
      rx_hard_n <= rx_meta;
    end
  end

  // single-cycle request: answered on the next edge
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // write and read strobes decoded once; each register process
  // then needs only its own strobe, so decode cannot drift apart
  assign wr_setup   = wb_req && wb_we_i && wb_sel_i[0]
                      && addr_hit(wb_adr_i, ERCR_PHY_SETUP_OFS);
  assign wr_scratch = wb_req && wb_we_i
                      && addr_hit(wb_adr_i, ERCR_SCRATCH_OFS);
  assign rd_req     = wb_req && !wb_we_i;

  // ack pulses one cycle, drops the cycle after
  // masking the request with ack stops a held stb being taken twice
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // phy setup register: only a write changes it, no self-clear
  // only the register reset clears it; datapath resets do not
  // bits above the three soft resets are not stored
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      phy_setup_register <= ERCR_PHY_SETUP_RST;
    end else if (wr_setup) begin
      phy_setup_register <= wb_dat_i[2:0];
    end
  end

  // scratch word for bus sanity checks
  // honours byte selects; no effect on the datapath resets
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      scratch <= ERCR_SCRATCH_RST;
    end else if (wr_scratch) begin
      scratch <= merge_bytes(scratch, wb_dat_i, wb_sel_i);
    end
  end

  // soft resets taken straight from the register bits
  // no other logic drives these, so software alone owns them
  assign soft_tx  = phy_setup_register[ERCR_SOFT_TX_BIT];
  assign soft_rx  = phy_setup_register[ERCR_SOFT_RX_BIT];
  assign soft_sys = phy_setup_register[ERCR_SOFT_SYS_BIT];

  // combine hard and soft sources; the core reset never feeds
  // back into the register file, so it stays intact
  // the core bit folds into both path resets as well
  always_comb begin
    next_tx_rst_n   = tx_hard_n && !soft_tx && !soft_sys;
    next_rx_rst_n   = rx_hard_n && !soft_rx && !soft_sys;
    next_xcvr_rst_n = csr_rst_n && !soft_sys;
  end

  // tx path reset out; async assert on register reset so the
  // datapath is held from the first moment the registers are
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      tx_path_rst_n <= 1'b0;
    end else begin
      tx_path_rst_n <= next_tx_rst_n;
    end
  end

  // rx path reset out, same timing as the tx side
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      rx_path_rst_n <= 1'b0;
    end else begin
      rx_path_rst_n <= next_rx_rst_n;
    end
  end

  // transceiver reset out; only register reset and core bit
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      xcvr_rst_n <= 1'b0;
    end else begin
      xcvr_rst_n <= next_xcvr_rst_n;
    end
  end

  // tx clock must be locked and settled before lanes report stable
  // the counter is held from the combined reset, so a soft reset
  // restarts the settle time rather than pausing it
  ercr_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_tx_settle (
    .sys_clk (sys_clk),
    .rst_n   (csr_rst_n),
    .hold    (!next_tx_rst_n),
    .locked  (tx_pll_locked),
    .done    (tx_settled)
  );

  // lanes settled falls with tx or core reset, rises after settle
  // taken from the combined reset, so it falls with tx_path_rst_n
  // and never shows stable while the tx path is still held
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      tx_lanes_stable <= 1'b0;
    end else begin
      tx_lanes_stable <= tx_settled && next_tx_rst_n;
    end
  end

  // rx ready needs rx out of reset and a locked receive link
  // no settle count here: the link lock already implies a
  // stable receive input
  assign next_rx_ready = next_rx_rst_n && rx_link_locked;

  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      rx_pcs_ready <= 1'b0;
    end else begin
      rx_pcs_ready <= next_rx_ready;
    end
  end

  // status word gathers live reset and link state
  // read-only; writes to this offset are dropped without error
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ERCR_ST_TX_STABLE_BIT] = tx_lanes_stable;
    status_word[ERCR_ST_RX_READY_BIT]  = rx_pcs_ready;
    status_word[ERCR_ST_TX_RST_BIT]    = !tx_path_rst_n;
    status_word[ERCR_ST_RX_RST_BIT]    = !rx_path_rst_n;
    status_word[ERCR_ST_XCVR_RST_BIT]  = !xcvr_rst_n;
  end

  // read mux; unmapped addresses read zero and still ack
  // decoded from the live address, sampled only on a read strobe
  always_comb begin
    if (addr_hit(wb_adr_i, ERCR_PHY_SETUP_OFS)) begin
      next_rdata = {29'h0000_0000, phy_setup_register};
    end else if (addr_hit(wb_adr_i, ERCR_STATUS_OFS)) begin
      next_rdata = status_word;
    end else if (addr_hit(wb_adr_i, ERCR_SCRATCH_OFS)) begin
      next_rdata = scratch;
    end else begin
      next_rdata = ERCR_UNMAPPED_DATA;
    end
  end

  // read data registered alongside ack
  always_ff @(posedge sys_clk or negedge csr_rst_n) begin
    if (!csr_rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// ---- pkg/ercr_pkg.sv ----
package ercr_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] ERCR_PHY_SETUP_OFS   = 8'h00;
  localparam logic [7:0] ERCR_STATUS_OFS      = 8'h04;
  localparam logic [7:0] ERCR_SCRATCH_OFS     = 8'h08;

  // phy setup register field positions
  localparam int ERCR_SOFT_TX_BIT   = 0;
  localparam int ERCR_SOFT_RX_BIT   = 1;
  localparam int ERCR_SOFT_SYS_BIT  = 2;

  // status register field positions
  localparam int ERCR_ST_TX_STABLE_BIT = 0;
  localparam int ERCR_ST_RX_READY_BIT  = 1;
  localparam int ERCR_ST_TX_RST_BIT    = 2;
  localparam int ERCR_ST_RX_RST_BIT    = 3;
  localparam int ERCR_ST_XCVR_RST_BIT  = 4;

  // reset values
  localparam logic [2:0]  ERCR_PHY_SETUP_RST = 3'h0;
  localparam logic [31:0] ERCR_SCRATCH_RST   = 32'h0000_0000;
  localparam logic [31:0] ERCR_UNMAPPED_DATA = 32'h0000_0000;

  // timing: settle time of transmit clock after reset release
  localparam int ERCR_CLK_HZ          = 25_000_000;
  localparam int ERCR_SETTLE_NS       = 1000;
  localparam int ERCR_SETTLE_CYC      =
    (ERCR_SETTLE_NS * (ERCR_CLK_HZ / 1_000_000) + 999) / 1000;

  // shortest legal transmit packet in bytes
  localparam int ERCR_MIN_PKT_BYTES   = 9;

endpackage

// ---- rtl/ercr_settle.sv ----
`timescale 1ns/100ps
// counts clock-stable time after a reset release; done is registered
module ercr_settle
  import ercr_pkg::*;
#(
  parameter int CYCLES = ERCR_SETTLE_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic hold,
  input  wire logic locked,
  // status
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] count;

  initial begin
    if (CYCLES < 1) $error("settle count must be at least one");
  end

  // counter restarts whenever held or the clock source is not locked
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (hold || !locked) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + CW'(1);
    end
  end

  // done only after the full count, dropped at once on hold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= !hold && locked && (count == LAST);
    end
  end

endmodule

// ---- test/ercr_top_props.sv ----
`timescale 1ns/100ps
module ercr_top_props
  import ercr_pkg::*;
(
  // clock and resets
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        tx_rst_n,
  input wire logic        rx_rst_n,
  // wishbone
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // reset and status outputs
  input wire logic        tx_path_rst_n,
  input wire logic        rx_path_rst_n,
  input wire logic        xcvr_rst_n,
  input wire logic        tx_lanes_stable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // setup write seen at the ack edge, while the master still holds it
  logic wr;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ERCR_PHY_SETUP_OFS;
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_tx_soft;
    wr && wb_dat_i[ERCR_SOFT_TX_BIT] |=> !tx_path_rst_n; endproperty
  a_tx_soft: assert property (p_tx_soft) else $error("tx soft");
  property p_sys_soft;
    wr && wb_dat_i[ERCR_SOFT_SYS_BIT] |=> !xcvr_rst_n && !tx_path_rst_n;
  endproperty
  a_sys_soft: assert property (p_sys_soft) else $error("core");
  property p_lanes;
    !tx_path_rst_n |-> !tx_lanes_stable; endproperty
  a_lanes: assert property (p_lanes) else $error("lanes up");
  property p_settle;
    $rose(tx_lanes_stable) |-> $past(tx_path_rst_n, 2); endproperty
  a_settle: assert property (p_settle) else $error("early");
  property p_tx_hard;
    !tx_rst_n |-> ##[1:4] !tx_path_rst_n; endproperty
  a_tx_hard: assert property (p_tx_hard) else $error("tx hard");
  property p_rx_hard;
    !rx_rst_n |-> ##[1:4] !rx_path_rst_n; endproperty
  a_rx_hard: assert property (p_rx_hard) else $error("rx hard");
  property p_rx_soft;
    wr && wb_dat_i[ERCR_SOFT_RX_BIT] |=> !rx_path_rst_n; endproperty
  a_rx_soft: assert property (p_rx_soft) else $error("rx soft");
endmodule

bind ercr_top ercr_top_props u_props (.sys_clk, .rst_n, .tx_rst_n,
  .rx_rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .tx_path_rst_n, .rx_path_rst_n, .xcvr_rst_n,
  .tx_lanes_stable);

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import ercr_pkg::*;
  logic        sys_clk, rst_n, tx_rst_n, rx_rst_n;
  logic        tx_pll_locked, rx_link_locked;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed, rd, d, scr_m;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic        tx_path_rst_n, rx_path_rst_n, xcvr_rst_n;
  logic        tx_lanes_stable, rx_pcs_ready;
  int          bad_count, samples_checked, setup_m;
  // short settle keeps the run brief
  ercr_top #(.SETTLE_CYCLES(2)) u_dut (.sys_clk, .rst_n, .tx_rst_n,
    .rx_rst_n, .tx_pll_locked, .rx_link_locked, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .tx_path_rst_n, .rx_path_rst_n, .xcvr_rst_n, .tx_lanes_stable,
    .rx_pcs_ready);
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status word model: settled, both links locked, no hard reset
  function automatic logic [31:0] stat(input int v);
    logic t, r, x;
    t = !(v[0] || v[2]);
    r = !(v[1] || v[2]);
    x = !v[2];
    return {27'h000_0000, !x, !r, !t, r, t};
  endfunction
  // one classic cycle; waits for ack, bounded so a hang is caught
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] dt, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) bad_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000, 4'hf);
    samples_checked++;
    if (rd !== e) begin
      bad_count++;
      $display("[ERR] %0t read %h exp %h", $time, rd, e);
    end
  endtask
  task automatic chk_pin(input logic [4:0] e);
    logic [4:0] g;
    g = {tx_path_rst_n, rx_path_rst_n, xcvr_rst_n, tx_lanes_stable,
         rx_pcs_ready};
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t pins %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    seed = 32'h0001_32a6;
    bad_count = 0;
    samples_checked = 0;
    {rst_n, tx_rst_n, rx_rst_n} = 3'h0;
    {tx_pll_locked, rx_link_locked} = 2'h3;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    repeat (4) @(posedge sys_clk);
    // no streaming client here, so no short packet is ever sent
    for (int k = 0; k < 2; k++) begin
      chk_pin(5'h00);
      rst_n <= 1'h1;
      tx_rst_n <= 1'h1;
      rx_rst_n <= 1'h1;
      repeat (12) @(posedge sys_clk);
      setup_m = 0;
      scr_m = ERCR_SCRATCH_RST;
      chk_rd(ERCR_PHY_SETUP_OFS, 32'h0000_0000);
      chk_rd(ERCR_SCRATCH_OFS, scr_m);
      chk_rd(8'h0c, ERCR_UNMAPPED_DATA);
      // random byte lanes into scratch
      for (int i = 0; i < 4; i++) begin
        d = rnd();
        wb(1'h1, ERCR_SCRATCH_OFS, rnd(), d[3:0]);
        for (int b = 0; b < 4; b++)
          if (d[b]) scr_m[8*b +: 8] = wb_dat_i[8*b +: 8];
        chk_rd(ERCR_SCRATCH_OFS, scr_m);
      end
      // every soft reset code, upper bits random, ends back at zero
      for (int v = 0; v < 9; v++) begin
        setup_m = v % 8;
        d = rnd();
        d[2:0] = setup_m[2:0];
        wb(1'h1, ERCR_PHY_SETUP_OFS, d, 4'h1);
        repeat (12) @(posedge sys_clk);
        d = stat(setup_m);
        chk_pin({d[0], d[1], !d[4], d[0], d[1]});
        chk_rd(ERCR_PHY_SETUP_OFS, setup_m);
        chk_rd(ERCR_STATUS_OFS, d);
        chk_rd(ERCR_SCRATCH_OFS, scr_m);
      end
      wb(1'h1, ERCR_PHY_SETUP_OFS, 32'h0000_0000, 4'h1);
      // hard resets, one direction at a time
      tx_rst_n <= 1'h0;
      repeat (6) @(posedge sys_clk);
      chk_pin(5'h0d);
      tx_rst_n <= 1'h1;
      rx_rst_n <= 1'h0;
      wb(1'h1, ERCR_PHY_SETUP_OFS, 32'h0000_0000, 4'h1);
      repeat (12) @(posedge sys_clk);
      chk_pin(5'h16);
      rx_rst_n <= 1'h1;
      rx_link_locked <= 1'h0;
      repeat (12) @(posedge sys_clk);
      chk_pin(5'h1e);
      tx_pll_locked <= 1'h0;
      repeat (12) @(posedge sys_clk);
      chk_pin(5'h1c);
      tx_pll_locked <= 1'h1;
      rx_link_locked <= 1'h1;
      wb(1'h1, ERCR_PHY_SETUP_OFS, 32'h0000_0005, 4'h1);
      rst_n <= 1'h0;
      repeat (3) @(posedge sys_clk);
    end
    wrap_up();
  end
endmodule
